// file: pcli_cfg.svh
`ifndef PCLI_CFG_SVH
`define PCLI_CFG_SVH
// Register byte addresses, one aligned word each
`define PCLI_ADDR_W 4
`define PCLI_OFF_CTRL 4'h0
`define PCLI_OFF_POL 4'h4
`define PCLI_OFF_LEVEL 4'h8
`define PCLI_OFF_STAT 4'hc
// Control register fields, reset values and source count
`define PCLI_CTRL_EN_BIT 0
`define PCLI_CTRL_RST 1'h0
`define PCLI_POL_RST 4'h0
`define PCLI_MASK_RST 4'h0
`define PCLI_NSRC 4
`endif

// file: pcli_irq.sv
`timescale 1ns/1ps
`include "pcli_cfg.svh"
module pcli_irq (
    input wire logic core_clk, // 200 MHz clock
    input wire logic rst, // Async reset, high
    input wire logic clk_en, // Freezes all state when low
    input wire logic [3:0] avs_address, // Byte address
    input wire logic avs_read, // Read strobe
    input wire logic avs_write, // Write strobe
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic [3:0] irq_source_line, // Pins of field_connector_main
    output logic irq_req, // Combined level request
    output logic evt_irq // Sticky-status interrupt
);
    // Three-stage synchroniser per pin
    pcli_pkg::pcli_src_t sync1_q, sync2_q, sync3_q, level_q;
    logic en_q;
    pcli_pkg::pcli_src_t pol_q, stat_q, mask_q;
    pcli_pkg::pcli_bus_t bus_q;
    logic [31:0] rdata_q;
    logic wr_ok, rd_ok;
    pcli_pkg::pcli_src_t cond;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
        end else if (clk_en) begin
            sync1_q <= irq_source_line;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Level accepted once stages two and three agree, filters one-cycle glitches
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            level_q <= 4'h0;
        end else if (clk_en) begin
            for (int i = 0; i < `PCLI_NSRC; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    level_q[i] <= sync3_q[i];
                end
            end
        end
    end

    assign cond = level_q ^ pol_q;

    // Bus handshake: one wait cycle, answer on the second
    assign wr_ok = avs_write && (bus_q == pcli_pkg::PCLI_BUS_ACK);
    assign rd_ok = avs_read && (bus_q == pcli_pkg::PCLI_BUS_ACK);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_q <= pcli_pkg::PCLI_BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else if (clk_en) begin
            unique case (bus_q)
                pcli_pkg::PCLI_BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_q <= pcli_pkg::PCLI_BUS_ACK;
                        avs_waitrequest <= 1'b0;
                    end
                end
                pcli_pkg::PCLI_BUS_ACK: begin
                    bus_q <= pcli_pkg::PCLI_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                // Unused code falls back to idle
                default: begin
                    bus_q <= pcli_pkg::PCLI_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Enable register; software is expected to set polarity first
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            en_q <= `PCLI_CTRL_RST;
        end else if (clk_en && wr_ok && avs_byteenable[0] && hit(avs_address, `PCLI_OFF_CTRL)) begin
            en_q <= avs_writedata[`PCLI_CTRL_EN_BIT];
        end
    end

    // polarity register, toggled by software on service
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pol_q <= `PCLI_POL_RST;
        end else if (clk_en && wr_ok && avs_byteenable[0] && hit(avs_address, `PCLI_OFF_POL)) begin
            pol_q <= avs_writedata[3:0];
        end
    end

    // Mask sits in the second byte of the control word, bits 11:8
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mask_q <= `PCLI_MASK_RST;
        end else if (clk_en && wr_ok && avs_byteenable[1] && hit(avs_address, `PCLI_OFF_CTRL)) begin
            mask_q <= avs_writedata[11:8];
        end
    end

    // Sticky source events; a new event wins over the read-clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stat_q <= 4'h0;
        end else if (clk_en) begin
            if (rd_ok && hit(avs_address, `PCLI_OFF_STAT)) begin
                // Only bits already reported are cleared, later arrivals survive
                stat_q <= cond | (stat_q & ~rdata_q[3:0]);
            end else begin
                stat_q <= stat_q | cond;
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else if (clk_en) begin
            if (avs_read && bus_q == pcli_pkg::PCLI_BUS_IDLE) begin
                unique case (avs_address)
                    `PCLI_OFF_CTRL: rdata_q <= {20'h0, mask_q, 7'h0, en_q};
                    `PCLI_OFF_POL: rdata_q <= {28'h0, pol_q};
                    `PCLI_OFF_LEVEL: rdata_q <= {28'h0, level_q};
                    `PCLI_OFF_STAT: rdata_q <= {28'h0, stat_q};
                    default: rdata_q <= 32'h0;
                endcase
            end
        end
    end
    assign avs_readdata = rdata_q;

    // OR of conditioned sources gated by enable
    // level request registered for a clean output
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_req <= 1'b0;
            evt_irq <= 1'b0;
        end else if (clk_en) begin
            irq_req <= en_q && (|cond);
            evt_irq <= |(stat_q & mask_q);
        end
    end

    property p_req_follows;
        @(posedge core_clk) disable iff (rst)
        clk_en |=> (irq_req == ($past(en_q) && (|($past(level_q) ^ $past(pol_q)))));
    endproperty
    a_req_follows: assert property (p_req_follows) else $error("request mismatch");

    property p_disabled_quiet;
        @(posedge core_clk) disable iff (rst)
        (!en_q && clk_en) |=> !irq_req;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("request while disabled");

    property p_level_hold;
        @(posedge core_clk) disable iff (rst)
        (en_q && (|cond) && clk_en) ##1 (en_q && (|cond) && clk_en) |=> irq_req;
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("request dropped");

    property p_pol;
        @(posedge core_clk) disable iff (rst)
        (clk_en && en_q && ((level_q & ~pol_q) == 4'h0) && ((~level_q & pol_q) == 4'h0)) |=> !irq_req;
    endproperty
    a_pol: assert property (p_pol) else $error("polarity wrong");

    property p_pol_inv;
        @(posedge core_clk) disable iff (rst)
        (clk_en && en_q && (|(pol_q & ~level_q))) |=> irq_req;
    endproperty
    a_pol_inv: assert property (p_pol_inv) else $error("inverted low level ignored");

    property p_sync;
        @(posedge core_clk) disable iff (rst)
        (clk_en && sync2_q == sync3_q) |=> level_q == $past(sync3_q);
    endproperty
    a_sync: assert property (p_sync) else $error("level not taken");

    // Disagreeing stages must not move the accepted level
    property p_sync_hold;
        @(posedge core_clk) disable iff (rst)
        (clk_en && (sync2_q != sync3_q)) |=> $stable(level_q);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("level moved on glitch");

    property p_stat_sticky;
        @(posedge core_clk) disable iff (rst)
        (clk_en && !(rd_ok && hit(avs_address, `PCLI_OFF_STAT))) |=> ((stat_q & $past(stat_q)) == $past(stat_q));
    endproperty
    a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost");

    property p_wait_one;
        @(posedge core_clk) disable iff (rst)
        (clk_en && !avs_waitrequest) |=> avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("answer held too long");

    property p_freeze;
        @(posedge core_clk) disable iff (rst)
        !clk_en |=> ($stable(irq_req) && $stable(level_q));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule

// file: pcli_pkg.sv
package pcli_pkg;
    typedef logic [3:0] pcli_src_t;
    typedef enum logic [1:0] {
        PCLI_BUS_IDLE,
        PCLI_BUS_ACK
    } pcli_bus_t;
endpackage

// file: pcli_src_model.sv
`timescale 1ns/1ps
// Field-side sources; each pin keeps its level until the bench changes it
module pcli_src_model (
    input wire logic [3:0] want, // Requested pin levels
    output logic [3:0] lines // Pins toward the block
);
    assign lines = want;
endmodule

// file: tb_port_c_level_interrupt_sources.sv
`timescale 1ns/1ps
`include "pcli_cfg.svh"
module tb_port_c_level_interrupt_sources;
    logic core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, en;
    logic [3:0] avs_address = 4'h0, want = 4'h0, pol, pins;
    logic [3:0] be = 4'hf, old_ref, fired;
    logic ce = 1'b1;
    logic [31:0] avs_writedata = 32'h0, rd, avs_readdata;
    logic avs_waitrequest, irq_req, evt_irq;
    wire logic [3:0] lines;
    int fail_count = 0, checked = 0;
    pcli_irq dut (.core_clk(core_clk), .rst(rst), .clk_en(ce), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq_source_line(lines), .irq_req(irq_req), .evt_irq(evt_irq));
    pcli_src_model src (.want(want), .lines(lines));
    // Bus clock, 5 ns period
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("checks=%0d mismatches=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One transfer; waits for the answer, only the watchdog ends a hang
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge core_clk);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask
    function automatic logic exp_irq(input logic e, input logic [3:0] p, input logic [3:0] q);
        return e & (|(p ^ q));
    endfunction
    // Pin sync plus registered request, with margin
    task settle;
        repeat (8) @(posedge core_clk);
    endtask
    // Main sequence
    initial begin
        void'($urandom(66135));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk(irq_req, 1'b0);
        chk(evt_irq, 1'b0);
        bus(1'b0, `PCLI_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        $display("reset test done");
        repeat (24) begin
            pol = 4'($urandom);
            pins = 4'($urandom);
            en = 1'($urandom);
            bus(1'b1, `PCLI_OFF_POL, {28'h0, pol});
            bus(1'b1, `PCLI_OFF_CTRL, {31'h0, en});
            want <= pins;
            settle;
            chk(irq_req, exp_irq(en, pins, pol));
            bus(1'b0, `PCLI_OFF_LEVEL, 32'h0);
            chk(rd[3:0], pins);
            chk(irq_req, exp_irq(en, pins, pol));
        end
        $display("random test done");
        for (int i = 0; i < 4; i++) begin
            want <= 4'(4'h1 << i);
            // idle low picks non-inverted, enable comes last
            bus(1'b1, `PCLI_OFF_POL, 32'h0);
            bus(1'b1, `PCLI_OFF_CTRL, 32'h1);
            settle;
            chk(irq_req, 1'b1);
            // serviced line gets its polarity flipped
            bus(1'b1, `PCLI_OFF_POL, 32'(4'h1 << i));
            settle;
            chk(irq_req, 1'b0);
        end
        $display("per-line test done");
        // Clear what the earlier tests left in the sticky status
        want <= 4'h0;
        bus(1'b1, `PCLI_OFF_POL, 32'h0);
        settle;
        bus(1'b0, `PCLI_OFF_STAT, 32'h0);
        want <= 4'h2;
        bus(1'b1, `PCLI_OFF_CTRL, 32'h201);
        settle;
        chk(evt_irq, 1'b1);
        want <= 4'h0;
        settle;
        bus(1'b0, `PCLI_OFF_STAT, 32'h0);
        chk(rd[3:0], 4'h2);
        bus(1'b0, `PCLI_OFF_STAT, 32'h0);
        chk(rd[3:0], 4'h0);
        chk(evt_irq, 1'b0);
        bus(1'b1, `PCLI_OFF_CTRL, 32'h101);
        want <= 4'h2;
        settle;
        chk(evt_irq, 1'b0);
        chk(irq_req, 1'b1);
        // Low byte lane only: enable cleared, mask kept
        be <= 4'h1;
        bus(1'b1, `PCLI_OFF_CTRL, 32'hf00);
        be <= 4'hf;
        bus(1'b0, `PCLI_OFF_CTRL, 32'h0);
        chk(rd, 32'h100);
        settle;
        chk(irq_req, 1'b0);
        $display("status test done");
        // Host service routine with line 0 plus a random set of the other lines
        want <= 4'h0;
        bus(1'b1, `PCLI_OFF_POL, 32'h0);
        bus(1'b1, `PCLI_OFF_CTRL, 32'h1);
        settle;
        bus(1'b0, `PCLI_OFF_LEVEL, 32'h0);
        old_ref = rd[3:0];
        pins = 4'($urandom) | 4'h1;
        want <= pins;
        settle;
        chk(irq_req, exp_irq(1'b1, pins, 4'h0));
        bus(1'b0, `PCLI_OFF_LEVEL, 32'h0);
        fired = rd[3:0] ^ old_ref;
        chk(fired, pins);
        // flip polarity of every serviced line
        bus(1'b1, `PCLI_OFF_POL, {28'h0, fired});
        old_ref = old_ref ^ fired;
        settle;
        chk(irq_req, exp_irq(1'b1, pins, fired));
        want <= 4'h0;
        settle;
        chk(irq_req, exp_irq(1'b1, 4'h0, fired));
        bus(1'b0, `PCLI_OFF_LEVEL, 32'h0);
        chk(rd[3:0] ^ old_ref, pins);
        $display("service test done");
        // Frozen block ignores the pins until the enable returns
        ce <= 1'b0;
        want <= pins;
        settle;
        chk(irq_req, exp_irq(1'b1, 4'h0, fired));
        ce <= 1'b1;
        settle;
        chk(irq_req, exp_irq(1'b1, pins, fired));
        $display("freeze test done");
        // Reset in mid-run clears the registers again
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk(irq_req, 1'b0);
        bus(1'b0, `PCLI_OFF_POL, 32'h0);
        chk(rd, 32'h0);
        $display("second reset test done");
        wrap_up;
    end
    // Hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        wrap_up;
    end
endmodule
